// ==== inc/scs_pkg.sv ====
package scs_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_DIVIDE = 8'h95;
   localparam logic [7:0] ADDR_SELECT = 8'h96;
   localparam logic [7:0] ADDR_ENABLE = 8'h97;
   localparam logic [7:0] SELECT_RESET = 8'h30;
   localparam logic [7:0] ENABLE_RESET = 8'h30;
   localparam logic [7:0] DIVIDE_RESET = 8'h00;
   // Reserved bit 4 reads back as one in both control registers.
   localparam logic [7:0] RSVD_ONES = 8'h10;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int FAST_STABLE_BIT = 5;
   localparam int EXT_STABLE_BIT = 3;
   localparam int CHOICE_LSB = 1;
   localparam int EXT_EN_LSB = 6;
   localparam int FAST_EN_BIT = 5;
   localparam int FAULT_BIT = 0;
   // ----------------------------------------------------------------
   // Source codes
   // ----------------------------------------------------------------
   localparam logic [1:0] SRC_FAST = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;
   localparam logic [1:0] SRC_SLOW = 2'h2;
   localparam logic [1:0] SRC_RSVD = 2'h3;
   localparam logic [1:0] EXT_ON_CODE = 2'h3;
   localparam logic [1:0] EXT_RESET = 2'h0;
   localparam logic [8:0] DIV_ZERO = 9'h000;
   // ----------------------------------------------------------------
   // Switch sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SCS_RUN = 3'b001,
      SCS_WAIT = 3'b010,
      SCS_SWAP = 3'b100
   } scs_state_t;
endpackage

// ==== rtl/scs_clock_switch.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - Select and enable registers write only while timed access is open.
// RULE2 - Select bit 5 shows fast oscillator enabled and stable.
// RULE3 - Select bit 3 shows external input enabled and stable.
// RULE4 - Choice 00 fast, 01 external, 10 slow, 11 reserved.
// RULE5 - Choice field reads back as written, not the active source.
// RULE6 - External input enabled only by enable field code 11.
// RULE7 - Enable bit 5 switches the fast oscillator on or off.
// RULE8 - Programming mode forces fast oscillator on, enable and stable set.
// RULE9 - Leaving programming mode restores the fast enable and stable bits.
// RULE10 - Fault flag reads zero after a successful switch.
// RULE11 - Fault set on bad target; held until unstable target settles.
// RULE12 - System clock is the source divided by an integer, down to 1/510.
// RULE13 - Divider changes take effect without stalling anything.
// RULE14 - A write disabling the running source is ignored entirely.
// RULE15 - Selecting a disabled source keeps the clock and sets fault.
// RULE16 - Enabled unstable target: wait, then switch and clear fault.
// RULE17 - Divider 00 passes the source; N gives source over 2N.
// RULE18 - Source changeover happens only while output is low, no runt.
// RULE19 - Reset selects a running fast oscillator, slow one enabled.
module scs_clock_switch (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_we,
   input wire logic timed_access,
   input wire logic in_app_program_enable,
   input wire logic fast_rc_tick,
   input wire logic slow_rc_tick,
   input wire logic ext_tick,
   input wire logic fast_rc_ready,
   input wire logic ext_ready,
   output logic [7:0] sfr_rdata,
   output logic fast_rc_on,
   output logic ext_input_on,
   output logic sys_clk_out,
   output logic [1:0] active_source
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [1:0] choice_q;
   logic [1:0] ext_en_q;
   logic fast_en_q;
   logic fault_q;
   logic [7:0] divide_q;
   logic [1:0] active_q;
   logic [1:0] target_q;
   logic [8:0] cnt_q;
   logic clk_q;
   scs_pkg::scs_state_t state_q;
   // Decoded status and strobes, all combinational.
   logic fast_eff, fast_stable, ext_en, ext_stable, src_tick;
   logic terminal, swap_now, sel_wr, en_wr, en_wr_ok;

   // Stable view of a source; the slow oscillator never goes away.
   function automatic logic src_stable(input logic [1:0] code,
                                       input logic fs, input logic es);
      if (code == scs_pkg::SRC_FAST) begin
         src_stable = fs;
      end else if (code == scs_pkg::SRC_EXT) begin
         src_stable = es;
      end else if (code == scs_pkg::SRC_SLOW) begin
         src_stable = 1'b1;
      end else begin
         src_stable = 1'b0;
      end
   endfunction

   // Enabled view of a source, before any settling.
   function automatic logic src_enabled(input logic [1:0] code,
                                        input logic fe, input logic ee);
      if (code == scs_pkg::SRC_FAST) begin
         src_enabled = fe;
      end else if (code == scs_pkg::SRC_EXT) begin
         src_enabled = ee;
      end else begin
         src_enabled = (code == scs_pkg::SRC_SLOW);
      end
   endfunction

   // ----------------------------------------------------------------
   // Status and decode
   // ----------------------------------------------------------------
   // RULE8 RULE9 forced enable: the stored bit is untouched, so it returns.
   assign fast_eff = fast_en_q | in_app_program_enable;
   // RULE2 fast status.
   assign fast_stable = in_app_program_enable | (fast_en_q & fast_rc_ready);
   // RULE6 external enable code.
   assign ext_en = (ext_en_q == scs_pkg::EXT_ON_CODE);
   // RULE3 external status.
   assign ext_stable = ext_en & ext_ready;
   // RULE1 timed access gate.
   assign sel_wr = sfr_we & timed_access & (sfr_addr == scs_pkg::ADDR_SELECT);
   assign en_wr = sfr_we & timed_access & (sfr_addr == scs_pkg::ADDR_ENABLE);
   // RULE14 refuse a write that would stop the running source.
   assign en_wr_ok = en_wr &&
      !((active_q == scs_pkg::SRC_FAST) && !sfr_wdata[scs_pkg::FAST_EN_BIT]
        && !in_app_program_enable) &&
      !((active_q == scs_pkg::SRC_EXT) &&
        (sfr_wdata[scs_pkg::EXT_EN_LSB +: 2] != scs_pkg::EXT_ON_CODE));

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // Enable register; RULE19 reset leaves the fast oscillator on.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_en_q <= scs_pkg::EXT_RESET;
         fast_en_q <= scs_pkg::ENABLE_RESET[scs_pkg::FAST_EN_BIT];
      end else if (en_wr_ok) begin
         // RULE7 fast enable bit.
         ext_en_q <= sfr_wdata[scs_pkg::EXT_EN_LSB +: 2];
         fast_en_q <= sfr_wdata[scs_pkg::FAST_EN_BIT];
      end
   end

   // RULE4 RULE5 choice field is stored as written and never rewritten.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         choice_q <= scs_pkg::SELECT_RESET[scs_pkg::CHOICE_LSB +: 2];
      end else if (sel_wr) begin
         choice_q <= sfr_wdata[scs_pkg::CHOICE_LSB +: 2];
      end
   end

   // RULE13 divider is open to writes at any time, all pages, unprotected.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divide_q <= scs_pkg::DIVIDE_RESET;
      end else if (sfr_we && sfr_addr == scs_pkg::ADDR_DIVIDE) begin
         divide_q <= sfr_wdata;
      end
   end

   // Registered read port; unmapped addresses read zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_addr == scs_pkg::ADDR_SELECT) begin
         sfr_rdata <= scs_pkg::RSVD_ONES |
            {2'h0, fast_stable, 1'b0, ext_stable, choice_q, 1'b0};
      end else if (sfr_addr == scs_pkg::ADDR_ENABLE) begin
         sfr_rdata <= scs_pkg::RSVD_ONES |
            {ext_en_q, fast_eff, 4'h0, fault_q};
      end else if (sfr_addr == scs_pkg::ADDR_DIVIDE) begin
         sfr_rdata <= divide_q;
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Switch sequencer
   // ----------------------------------------------------------------
   // Changeover lands on a falling output edge; a select write wins it.
   assign swap_now = (state_q == scs_pkg::SCS_SWAP) && terminal && clk_q
      && !sel_wr;

   // A new select write always restarts the decision, even mid-wait.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= scs_pkg::SCS_RUN;
         target_q <= scs_pkg::SRC_FAST;
         fault_q <= 1'b0;
      end else if (sel_wr) begin
         target_q <= sfr_wdata[scs_pkg::CHOICE_LSB +: 2];
         if (!src_enabled(sfr_wdata[scs_pkg::CHOICE_LSB +: 2], fast_eff,
                          ext_en)) begin
            // RULE15 disabled target: flag it, keep the clock.
            state_q <= scs_pkg::SCS_RUN;
            fault_q <= 1'b1;
         end else if (!src_stable(sfr_wdata[scs_pkg::CHOICE_LSB +: 2],
                                  fast_stable, ext_stable)) begin
            // RULE11 unstable target: flag until it settles.
            state_q <= scs_pkg::SCS_WAIT;
            fault_q <= 1'b1;
         end else begin
            state_q <= scs_pkg::SCS_SWAP;
         end
      end else begin
         case (state_q)
            scs_pkg::SCS_WAIT: begin
               // RULE16 background wait for stability.
               if (src_stable(target_q, fast_stable, ext_stable)) begin
                  state_q <= scs_pkg::SCS_SWAP;
               end
            end
            scs_pkg::SCS_SWAP: begin
               // RULE10 success clears the flag.
               if (swap_now) begin
                  state_q <= scs_pkg::SCS_RUN;
                  fault_q <= 1'b0;
               end
            end
            default: begin
               state_q <= scs_pkg::SCS_RUN;
            end
         endcase
      end
   end

   // RULE18 source changes only at a falling output edge.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_q <= scs_pkg::SRC_FAST;
      end else if (swap_now) begin
         active_q <= target_q;
      end
   end

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   // Each tick marks one half period of the chosen oscillator.
   always_comb begin
      if (active_q == scs_pkg::SRC_EXT) begin
         src_tick = ext_tick;
      end else if (active_q == scs_pkg::SRC_SLOW) begin
         src_tick = slow_rc_tick;
      end else begin
         src_tick = fast_rc_tick;
      end
   end

   // RULE17 half period is one tick for 00, else 2N ticks (up to 510).
   assign terminal = src_tick &&
      ((divide_q == 8'h00) || (cnt_q + 9'h001 >= {divide_q, 1'b0}));

   // RULE12 RULE13 divide value is compared on every source tick, so a new one acts within the current half period.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= scs_pkg::DIV_ZERO;
         clk_q <= 1'b0;
      end else if (terminal) begin
         cnt_q <= scs_pkg::DIV_ZERO;
         clk_q <= ~clk_q;
      end else if (src_tick) begin
         cnt_q <= cnt_q + 9'h001;
      end
   end

   // Pin and oscillator controls; the slow oscillator is always on.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fast_rc_on <= 1'b1;
         ext_input_on <= 1'b0;
         sys_clk_out <= 1'b0;
         active_source <= scs_pkg::SRC_FAST;
      end else begin
         fast_rc_on <= fast_eff;
         ext_input_on <= ext_en;
         sys_clk_out <= clk_q;
         active_source <= active_q;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence locked_sel_write;
      sfr_we && !timed_access && sfr_addr == scs_pkg::ADDR_SELECT;
   endsequence
   sequence bad_target_write;
      sel_wr && !src_enabled(sfr_wdata[2:1], fast_eff, ext_en);
   endsequence

   locked_select_a: assert property (@(posedge clk) disable iff (rst) // RULE1
      locked_sel_write |=> $stable(choice_q))
      else $error("Select changed without timed access.");
   fast_status_a: assert property (@(posedge clk) disable iff (rst) // RULE2
      sfr_addr == scs_pkg::ADDR_SELECT |=> sfr_rdata[5] == $past(fast_stable))
      else $error("Fast status bit wrong.");
   ext_status_a: assert property (@(posedge clk) disable iff (rst) // RULE3
      sfr_addr == scs_pkg::ADDR_SELECT |=> sfr_rdata[3] == $past(ext_stable))
      else $error("External status bit wrong.");
   forced_fast_a: assert property (@(posedge clk) disable iff (rst) // RULE8
      in_app_program_enable [*2] |-> fast_rc_on && fast_stable)
      else $error("Fast oscillator not forced on.");
   keep_running_a: assert property (@(posedge clk) disable iff (rst) // RULE14
      active_q == scs_pkg::SRC_FAST && en_wr && !sfr_wdata[5] &&
      !in_app_program_enable |=> $stable(fast_en_q) && $stable(ext_en_q))
      else $error("Running source was disabled.");
   disabled_target_a: assert property (@(posedge clk) disable iff (rst) // RULE15
      bad_target_write |=> fault_q && $stable(active_q))
      else $error("Disabled target not flagged.");
   switch_done_a: assert property (@(posedge clk) disable iff (rst) // RULE16
      swap_now && !sel_wr |=> !fault_q && active_q == $past(target_q))
      else $error("Switch did not complete cleanly.");
   edge_on_tick_a: assert property (@(posedge clk) disable iff (rst) // RULE17
      $changed(clk_q) |-> $past(src_tick))
      else $error("Output edge without source tick.");
   low_swap_a: assert property (@(posedge clk) disable iff (rst) // RULE18
      $changed(active_q) |-> !clk_q)
      else $error("Source changed while output high.");
endmodule // scs_clock_switch

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   logic clk;
   logic rst;
   logic [7:0] sfr_addr;
   logic [7:0] sfr_wdata;
   logic sfr_we;
   logic timed_access;
   logic in_app_program_enable;
   logic fast_rc_tick;
   logic slow_rc_tick;
   logic ext_tick;
   logic fast_rc_ready;
   logic ext_ready;
   logic [7:0] sfr_rdata;
   logic fast_rc_on;
   logic ext_input_on;
   logic sys_clk_out;
   logic [1:0] active_source;
   logic rd_req;
   logic rd_seen;
   logic [3:0] phase;
   logic [7:0] exp_q[$];
   logic [7:0] dv;
   logic [31:0] rnd;
   int mismatches;
   int tests_run;
   int cycles;
   int seed;

   scs_clock_switch scs_clock_switch_inst (
      .clk(clk),
      .rst(rst),
      .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata),
      .sfr_we(sfr_we),
      .timed_access(timed_access),
      .in_app_program_enable(in_app_program_enable),
      .fast_rc_tick(fast_rc_tick),
      .slow_rc_tick(slow_rc_tick),
      .ext_tick(ext_tick),
      .fast_rc_ready(fast_rc_ready),
      .ext_ready(ext_ready),
      .sfr_rdata(sfr_rdata),
      .fast_rc_on(fast_rc_on),
      .ext_input_on(ext_input_on),
      .sys_clk_out(sys_clk_out),
      .active_source(active_source)
   );

   // ---------------------------------------------------------------
   // Clock, oscillator ticks and watchdog
   // ---------------------------------------------------------------
   // Ticks are spaced so that no two pulses of one source touch.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      phase <= phase + 4'h1;
      fast_rc_tick <= phase[0];
      ext_tick <= (phase[1:0] == 2'h3);
      slow_rc_tick <= (phase == 4'hF);
      rd_seen <= rd_req;
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // Comparison and closing
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Read data lags the address by one edge, so the note is taken then.
   always @(negedge clk) begin
      if (rd_seen) begin
         if (exp_q.size() == 0) begin
            chk(16'hFFFF, 16'h0000);
         end else begin
            chk({8'h00, sfr_rdata}, {8'h00, exp_q.pop_front()});
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic ta);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_we <= 1'b1;
      timed_access <= ta;
      @(posedge clk);
      sfr_we <= 1'b0;
      timed_access <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      sfr_addr <= a;
      rd_req <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd_req <= 1'b0;
   endtask
   task automatic settle();
      repeat (3) @(negedge clk);
   endtask
   task automatic wait_src(input logic [1:0] s);
      int n;
      n = 0;
      while (active_source !== s && n < 400) begin
         @(negedge clk);
         n++;
      end
      chk({14'h0000, active_source}, {14'h0000, s});
   endtask
   // The first periods after a divider change may be transitional.
   task automatic period(input logic [15:0] e);
      realtime t0;
      repeat (2) @(posedge sys_clk_out);
      t0 = $realtime;
      @(posedge sys_clk_out);
      chk(16'(int'(($realtime - t0) / 50.0)), e);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      seed = 32'hE47C;
      rst = 1'b1;
      {sfr_addr, sfr_wdata, sfr_we, timed_access} = 18'h00000;
      {in_app_program_enable, ext_ready, rd_req, rd_seen} = 4'h0;
      {fast_rc_tick, slow_rc_tick, ext_tick, phase} = 7'h00;
      fast_rc_ready = 1'b1;
      cycles = 0;
      mismatches = 0;
      tests_run = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(8'h96, 8'h30);
      rd(8'h97, 8'h30);
      rd(8'h95, 8'h00);
      rd(8'h90, 8'h00);
      chk({14'h0000, active_source}, 16'h0000);
      chk({15'h0000, ext_input_on}, 16'h0000);
      wr(8'h97, 8'hF0, 1'b0);
      rd(8'h97, 8'h30);
      wr(8'h96, 8'h04, 1'b0);
      rd(8'h96, 8'h30);
      wr(8'h97, 8'h10, 1'b1);
      rd(8'h97, 8'h30);
      wr(8'h96, 8'h02, 1'b1);
      settle();
      chk({14'h0000, active_source}, 16'h0000);
      rd(8'h96, 8'h32);
      rd(8'h97, 8'h31);
      wr(8'h97, 8'hF0, 1'b1);
      settle();
      chk({15'h0000, ext_input_on}, 16'h0001);
      rd(8'h96, 8'h32);
      wr(8'h96, 8'h02, 1'b1);
      rd(8'h97, 8'hF1);
      ext_ready <= 1'b1;
      rd(8'h96, 8'h3A);
      wait_src(2'h1);
      rd(8'h97, 8'hF0);
      wr(8'h97, 8'h30, 1'b1);
      rd(8'h97, 8'hF0);
      wr(8'h97, 8'hD0, 1'b1);
      settle();
      chk({15'h0000, fast_rc_on}, 16'h0000);
      rd(8'h96, 8'h1A);
      @(posedge clk);
      in_app_program_enable <= 1'b1;
      settle();
      chk({15'h0000, fast_rc_on}, 16'h0001);
      rd(8'h97, 8'hF0);
      rd(8'h96, 8'h3A);
      @(posedge clk);
      in_app_program_enable <= 1'b0;
      settle();
      rd(8'h97, 8'hD0);
      rd(8'h96, 8'h1A);
      wr(8'h96, 8'h04, 1'b1);
      wait_src(2'h2);
      rd(8'h97, 8'hD0);
      wr(8'h96, 8'h00, 1'b1);
      settle();
      chk({14'h0000, active_source}, 16'h0002);
      rd(8'h97, 8'hD1);
      wr(8'h96, 8'h06, 1'b1);
      rd(8'h96, 8'h1E);
      rd(8'h97, 8'hD1);
      fast_rc_ready <= 1'b0;
      wr(8'h97, 8'hF0, 1'b1);
      wr(8'h96, 8'h00, 1'b1);
      rd(8'h97, 8'hF1);
      rd(8'h96, 8'h18);
      fast_rc_ready <= 1'b1;
      wait_src(2'h0);
      rd(8'h97, 8'hF0);
      // Fast ticks come every two cycles, so one tick is two cycles.
      for (int i = 0; i < 3; i++) begin
         rnd = $random(seed);
         dv = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : ({5'h00, rnd[2:0]} | 8'h01);
         wr(8'h95, dv, 1'b0);
         rd(8'h95, dv);
         period((dv == 8'h00) ? 16'h0004 : {5'h00, dv, 3'h0});
      end
      wrap_up();
   end
endmodule // tb_top
